// File: fault_pkg.sv
package fault_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int WDOG_MS = 200;
    localparam int WDOG_CYC = CLK_HZ / 1000 * WDOG_MS;
    // speed-loss time in tenths of a second, 99.9 s disables
    localparam logic [9:0] SPD_TIME_OFF = 10'h3E7;
    // torque-limit time in seconds, 999 s disables
    localparam logic [9:0] TRQ_TIME_OFF = 10'h3E7;
    localparam logic [3:0] TICKS_PER_S = 4'hA;
    localparam logic [2:0] MODE_VEC_SL = 3'h3;
    localparam logic [2:0] MODE_VEC_ENC = 3'h4;
    localparam logic [7:0] CODE_ZERO = 8'h00;
    localparam logic [7:0] CODE_BLOCKED = 8'h09;
    localparam logic [7:0] CODE_CONFLICT = 8'h18;
    localparam logic [7:0] CODE_KEYPAD = 8'h1F;
    localparam logic [7:0] CODE_SPEED_LOSS = 8'h21;
    localparam logic [7:0] CODE_TRQ_TIMEOUT = 8'h22;
    localparam logic [7:0] CODE_SELF_DIAG = 8'h29;
    localparam logic [7:0] CODE_WDOG = 8'h47;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SPD = 8'h04;
    localparam logic [7:0] ADDR_TRQ = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_CMD = 8'h18;
    localparam int CTRL_BACKUP = 3;
    localparam int SPD_TIME_LSB = 16;
    localparam int STAT_TRIP = 8;
    localparam int STAT_PWM = 9;
    localparam int CMD_RESET = 0;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] MAXERR_RST = 16'h0064;
    localparam logic [9:0] SPD_TIME_RST = SPD_TIME_OFF;
    localparam logic [9:0] TRQ_TIME_RST = TRQ_TIME_OFF;
    localparam int IRQ_W = 4;
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_CONFLICT = 1;
    localparam int IRQ_KEYPAD = 2;
    localparam int IRQ_DIAG = 3;
    localparam logic [3:0] LAMP_ON_TICKS = 4'h2;
    localparam logic [3:0] LAMP_OFF_TICKS = 4'h2;
    localparam logic [3:0] LAMP_PAUSE_TICKS = 4'hA;
    typedef enum logic [4:0] {
        L_IDLE = 5'h01, L_ON = 5'h02, L_OFF = 5'h04, L_PAUSE = 5'h08, L_STEADY = 5'h10
    } lamp_t;
endpackage

// File: drive_fault_supervisor.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - speed error too long raises speed-loss fault
// - speed-loss time 99.9 disables that detection
// - both timed faults only in vector modes
// - torque limiting too long trips timeout fault
// - torque-limit time 999 disables that detection
// - trip drops relay, stops pwm, shows, flashes
// - trip logs code, overload, timers, reference
// - blocked or self-diagnosis refuses motor run
// - conflict shows code, blocks drive, flips relays
// - keypad loss keeps running, ignores keypad
// - keypad fault never enters fault history
// - lamp off when ready, flashes code count
// - conflict clears itself once settings fixed
// - coprocessor silent over 200 ms trips
module drive_fault_supervisor #(
    parameter int TICK_CYCLES = fault_pkg::TICK_CYC,
    parameter int WDOG_CYCLES = fault_pkg::WDOG_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic signed [15:0] speed_actual,
    input wire logic signed [15:0] speed_command,
    input wire logic torque_limiting,
    input wire logic coproc_present,
    input wire logic coproc_alive,
    input wire logic ext_trip,
    input wire logic [7:0] ext_trip_code,
    input wire logic parameter_conflict_fault,
    input wire logic keypad_link_ok,
    input wire logic self_diagnosis_fault,
    input wire logic operation_blocked_fault,
    input wire logic fault_reset,
    input wire logic [15:0] overload_state,
    input wire logic [31:0] powered_time_counter,
    input wire logic [31:0] enabled_time_counter,
    input wire logic [15:0] speed_reference,
    output logic no_fault_relay,
    output logic with_error_relay,
    output logic pwm_enable,
    output logic motor_run_permit,
    output logic keypad_cmd_enable,
    output logic [7:0] display_code,
    output logic display_valid,
    output logic error_lamp,
    output logic nv_write,
    output logic [7:0] nv_code,
    output logic [15:0] nv_overload,
    output logic [31:0] nv_powered_time,
    output logic [31:0] nv_enabled_time,
    output logic nv_ref_valid,
    output logic [15:0] nv_speed_ref,
    output logic hist_write
);
    import fault_pkg::*;

    function automatic logic [13:0] sat_step(input logic [13:0] v, input logic go);
        sat_step = (go && v != 14'h3FFF) ? v + 14'h0001 : v;
    endfunction

    // registers
    logic [2:0] mode_q, mode_d;
    logic backup_q, backup_d;
    logic [15:0] maxerr_q, maxerr_d;
    logic [9:0] spd_time_q, spd_time_d;
    logic [9:0] trq_time_q, trq_time_d;
    logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, iev;
    logic [31:0] prdata_q, prdata_d;
    logic sw_reset;
    logic setup, wr, rd, mapped;
    logic [31:0] rmux;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign mapped = paddr inside {ADDR_CTRL, ADDR_SPD, ADDR_TRQ, ADDR_STAT,
                                  ADDR_IRQ_ST, ADDR_IRQ_MASK, ADDR_CMD};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;
    assign irq = |(ist_q & imask_q);

    // fault state
    logic trip_q, trip_d;
    logic [7:0] code_q, code_d;
    logic [7:0] disp_q, disp_d;
    logic dval_q, dval_d;
    logic nrel_q, nrel_d, erel_q, erel_d, pwm_q, pwm_d, run_q, run_d, kp_q, kp_d;
    logic nvw_q, nvw_d, hist_q, hist_d;
    logic [7:0] nvc_q, nvc_d;
    logic [15:0] nvo_q, nvo_d, nvr_q, nvr_d;
    logic [31:0] nvp_q, nvp_d, nve_q, nve_d;
    logic nvrv_q, nvrv_d;
    logic [23:0] tick_q, tick_d;
    logic tick;
    logic [13:0] sl_cnt_q, sl_cnt_d, tq_cnt_q, tq_cnt_d;
    logic [23:0] wd_cnt_q, wd_cnt_d;
    logic vector, spd_err, sl_fault, tq_fault, wd_fault, trip_ev, trip_set;
    logic [16:0] diff, adiff;
    logic [13:0] tq_limit;
    logic [7:0] ev_code;

    always_comb begin
        rmux = 32'h0000_0000;
        unique case (paddr)
            ADDR_CTRL: rmux = {28'h0, backup_q, mode_q};
            ADDR_SPD: rmux = {6'h0, spd_time_q, maxerr_q};
            ADDR_TRQ: rmux = {22'h0, trq_time_q};
            ADDR_STAT: rmux = {22'h0, pwm_q, trip_q, disp_q};
            ADDR_IRQ_ST: rmux = {28'h0, ist_q};
            ADDR_IRQ_MASK: rmux = {28'h0, imask_q};
            default: rmux = 32'h0000_0000;
        endcase
        prdata_d = setup ? rmux : prdata_q;
        mode_d = mode_q;
        backup_d = backup_q;
        maxerr_d = maxerr_q;
        spd_time_d = spd_time_q;
        trq_time_d = trq_time_q;
        imask_d = imask_q;
        sw_reset = 1'b0;
        if (wr) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    mode_d = pwdata[2:0];
                    backup_d = pwdata[CTRL_BACKUP];
                end
                ADDR_SPD: begin
                    maxerr_d = pwdata[15:0];
                    spd_time_d = pwdata[SPD_TIME_LSB +: 10];
                end
                ADDR_TRQ: trq_time_d = pwdata[9:0];
                ADDR_IRQ_MASK: imask_d = pwdata[IRQ_W-1:0];
                ADDR_CMD: sw_reset = pwdata[CMD_RESET];
                default: ;
            endcase
        end
        // set wins over the read clear; only bits already read are cleared
        ist_d = (ist_q & ~((rd && paddr == ADDR_IRQ_ST) ? prdata_q[IRQ_W-1:0] : '0)) | iev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= CTRL_RST;
            backup_q <= 1'b0;
            maxerr_q <= MAXERR_RST;
            spd_time_q <= SPD_TIME_RST;
            trq_time_q <= TRQ_TIME_RST;
            imask_q <= '0;
            ist_q <= '0;
            prdata_q <= 32'h0000_0000;
        end else begin
            mode_q <= mode_d;
            backup_q <= backup_d;
            maxerr_q <= maxerr_d;
            spd_time_q <= spd_time_d;
            trq_time_q <= trq_time_d;
            imask_q <= imask_d;
            ist_q <= ist_d;
            prdata_q <= prdata_d;
        end
    end

    assign tick = tick_q == 24'(TICK_CYCLES - 1);
    assign vector = mode_q == MODE_VEC_SL || mode_q == MODE_VEC_ENC;
    assign diff = {speed_actual[15], speed_actual} - {speed_command[15], speed_command};
    assign adiff = diff[16] ? 17'(-diff) : diff;
    assign spd_err = adiff > {1'b0, maxerr_q};
    assign tq_limit = 14'(trq_time_q) * 14'(TICKS_PER_S);
    assign sl_fault = vector && spd_time_q != SPD_TIME_OFF
                      && sl_cnt_q > {4'h0, spd_time_q};
    assign tq_fault = vector && trq_time_q != TRQ_TIME_OFF
                      && tq_cnt_q > tq_limit;
    assign wd_fault = coproc_present && wd_cnt_q > 24'(WDOG_CYCLES);
    assign trip_ev = ext_trip || sl_fault || tq_fault || wd_fault;
    assign trip_set = trip_ev && (!trip_q || fault_reset || sw_reset);

    always_comb begin
        tick_d = tick ? 24'h0 : tick_q + 24'h1;
        sl_cnt_d = (vector && spd_err) ? sat_step(sl_cnt_q, tick) : 14'h0;
        tq_cnt_d = (vector && torque_limiting) ? sat_step(tq_cnt_q, tick) : 14'h0;
        wd_cnt_d = (coproc_alive || !coproc_present) ? 24'h0
                 : (wd_fault ? wd_cnt_q : wd_cnt_q + 24'h1);
        ev_code = ext_trip ? ext_trip_code : sl_fault ? CODE_SPEED_LOSS
                : tq_fault ? CODE_TRQ_TIMEOUT : CODE_WDOG;
        // latched until reset; a new event in the clear cycle still trips
        trip_d = trip_q;
        code_d = code_q;
        if (fault_reset || sw_reset) begin
            trip_d = 1'b0;
        end
        if (trip_set) begin
            trip_d = 1'b1;
            code_d = ev_code;
        end
        // one code shown, trip first
        dval_d = 1'b1;
        if (trip_q) disp_d = code_q;
        else if (self_diagnosis_fault) disp_d = CODE_SELF_DIAG;
        else if (parameter_conflict_fault) disp_d = CODE_CONFLICT;
        else if (!keypad_link_ok) disp_d = CODE_KEYPAD;
        else begin
            disp_d = disp_q;
            dval_d = 1'b0;
        end
        nrel_d = !(trip_q || parameter_conflict_fault);
        erel_d = trip_q || parameter_conflict_fault;
        pwm_d = !(trip_q || parameter_conflict_fault
                  || self_diagnosis_fault || operation_blocked_fault);
        run_d = pwm_d;
        kp_d = keypad_link_ok;
        // keypad loss never reaches the trip path, so no log
        nvw_d = trip_set;
        hist_d = trip_set;
        nvc_d = nvw_d ? ev_code : nvc_q;
        nvo_d = nvw_d ? overload_state : nvo_q;
        nvp_d = nvw_d ? powered_time_counter : nvp_q;
        nve_d = nvw_d ? enabled_time_counter : nve_q;
        nvr_d = nvw_d ? speed_reference : nvr_q;
        nvrv_d = nvw_d ? backup_q : nvrv_q;
        iev = '0;
        iev[IRQ_TRIP] = trip_set;
        iev[IRQ_CONFLICT] = parameter_conflict_fault;
        iev[IRQ_KEYPAD] = !keypad_link_ok;
        iev[IRQ_DIAG] = self_diagnosis_fault;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 24'h0;
            sl_cnt_q <= 14'h0;
            tq_cnt_q <= 14'h0;
            wd_cnt_q <= 24'h0;
            trip_q <= 1'b0;
            code_q <= CODE_ZERO;
            disp_q <= CODE_ZERO;
            dval_q <= 1'b0;
            nrel_q <= 1'b0;
            erel_q <= 1'b0;
            pwm_q <= 1'b0;
            run_q <= 1'b0;
            kp_q <= 1'b0;
            nvw_q <= 1'b0;
            hist_q <= 1'b0;
            nvc_q <= CODE_ZERO;
            nvo_q <= 16'h0;
            nvp_q <= 32'h0;
            nve_q <= 32'h0;
            nvr_q <= 16'h0;
            nvrv_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            sl_cnt_q <= sl_cnt_d;
            tq_cnt_q <= tq_cnt_d;
            wd_cnt_q <= wd_cnt_d;
            trip_q <= trip_d;
            code_q <= code_d;
            disp_q <= disp_d;
            dval_q <= dval_d;
            nrel_q <= nrel_d;
            erel_q <= erel_d;
            pwm_q <= pwm_d;
            run_q <= run_d;
            kp_q <= kp_d;
            nvw_q <= nvw_d;
            hist_q <= hist_d;
            nvc_q <= nvc_d;
            nvo_q <= nvo_d;
            nvp_q <= nvp_d;
            nve_q <= nve_d;
            nvr_q <= nvr_d;
            nvrv_q <= nvrv_d;
        end
    end

    // lamp flashes a shown trip or self-diagnosis code; pause lets the count be read
    lamp_t ls_q, ls_d;
    logic [3:0] ph_q, ph_d;
    logic [7:0] fl_q, fl_d;
    logic lamp_act;
    assign lamp_act = dval_q && (trip_q || disp_q == CODE_SELF_DIAG);

    always_comb begin
        ls_d = ls_q;
        ph_d = tick ? ph_q + 4'h1 : ph_q;
        fl_d = fl_q;
        unique case (ls_q)
            L_IDLE: begin
                ph_d = 4'h0;
                fl_d = 8'h0;
                if (lamp_act) ls_d = (disp_q == CODE_ZERO) ? L_STEADY : L_ON;
            end
            L_ON: if (tick && ph_q == LAMP_ON_TICKS - 4'h1) begin
                ls_d = L_OFF;
                ph_d = 4'h0;
                fl_d = fl_q + 8'h1;
            end
            L_OFF: if (tick && ph_q == LAMP_OFF_TICKS - 4'h1) begin
                ls_d = (fl_q == disp_q) ? L_PAUSE : L_ON;
                ph_d = 4'h0;
            end
            L_PAUSE: if (tick && ph_q == LAMP_PAUSE_TICKS - 4'h1) begin
                ls_d = L_ON;
                ph_d = 4'h0;
                fl_d = 8'h0;
            end
            L_STEADY: if (disp_q != CODE_ZERO) ls_d = L_IDLE;
            default: ls_d = L_IDLE;
        endcase
        if (!lamp_act) ls_d = L_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_q <= L_IDLE;
            ph_q <= 4'h0;
            fl_q <= 8'h0;
        end else begin
            ls_q <= ls_d;
            ph_q <= ph_d;
            fl_q <= fl_d;
        end
    end

    assign error_lamp = ls_q == L_ON || ls_q == L_STEADY;
    assign no_fault_relay = nrel_q;
    assign with_error_relay = erel_q;
    assign pwm_enable = pwm_q;
    assign motor_run_permit = run_q;
    assign keypad_cmd_enable = kp_q;
    assign display_code = disp_q;
    assign display_valid = dval_q;
    assign nv_write = nvw_q;
    assign hist_write = hist_q;
    assign nv_code = nvc_q;
    assign nv_overload = nvo_q;
    assign nv_powered_time = nvp_q;
    assign nv_enabled_time = nve_q;
    assign nv_speed_ref = nvr_q;
    assign nv_ref_valid = nvrv_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    trip_hold_a: assert property (trip_q && !fault_reset && !sw_reset |=> trip_q)
        else $error("trip dropped without reset");
    sl_mode_a: assert property (!vector |-> !sl_fault && !tq_fault)
        else $error("timed fault outside vector mode");
    sl_off_a: assert property (spd_time_q == SPD_TIME_OFF |-> !sl_fault)
        else $error("speed loss while disabled");
    tq_off_a: assert property (trq_time_q == TRQ_TIME_OFF |-> !tq_fault)
        else $error("torque timeout while disabled");
    sl_time_a: assert property (sl_fault |-> $past(spd_err)
        && $past(sl_cnt_q) >= {4'h0, spd_time_q}) else $error("speed loss too early");
    tq_time_a: assert property (tq_fault |-> $past(tq_cnt_q) >= tq_limit)
        else $error("torque timeout too early");
    trip_out_a: assert property (trip_q |=> !no_fault_relay && !pwm_enable)
        else $error("trip outputs not applied");
    conflict_a: assert property (parameter_conflict_fault |=> with_error_relay
        && !motor_run_permit) else $error("conflict outputs not applied");
    block_a: assert property (operation_blocked_fault |=> !motor_run_permit)
        else $error("blocked drive still runs");
    keypad_a: assert property (!keypad_link_ok && !trip_q && !parameter_conflict_fault
        && !self_diagnosis_fault |=> !keypad_cmd_enable && display_code == CODE_KEYPAD)
        else $error("keypad loss mishandled");
    log_a: assert property ($rose(trip_q) |-> nv_write && hist_write
        && nv_code == code_q && nv_code != CODE_KEYPAD) else $error("trip not logged");
    lamp_off_a: assert property (!lamp_act |=> !error_lamp)
        else $error("lamp lit while ready");
    wdog_a: assert property (coproc_alive |=> !wd_fault)
        else $error("watchdog fault after heartbeat");
    trip_c: cover property ($rose(trip_q) ##[1:20] !trip_q);
    lamp_c: cover property (ls_q == L_OFF ##1 ls_q == L_PAUSE);
    irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fault_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [15:0] speed_actual, speed_command;
    logic torque_limiting, coproc_present, coproc_alive, ext_trip, fault_reset, err;
    logic [7:0] ext_trip_code, display_code, nv_code;
    logic parameter_conflict_fault, keypad_link_ok, self_diagnosis_fault, operation_blocked_fault;
    logic [15:0] overload_state, speed_reference, nv_overload, nv_speed_ref;
    logic [31:0] powered_time_counter, enabled_time_counter, nv_powered_time, nv_enabled_time;
    logic no_fault_relay, with_error_relay, pwm_enable, motor_run_permit, keypad_cmd_enable;
    logic display_valid, error_lamp, nv_write, nv_ref_valid, hist_write;
    int error_cnt = 0, tests_run = 0, cyc = 0, hist_seen = 0, n, rises;
    integer seed = 32'hcb31ce2d;
    // bench model state: latched trip, its code, reference backup flag
    logic m_trip = 0, m_bk = 0, prev;
    logic [7:0] m_code = 8'h00;

    drive_fault_supervisor #(.TICK_CYCLES(4), .WDOG_CYCLES(50)) drive_fault_supervisor_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .speed_actual(speed_actual), .speed_command(speed_command),
        .torque_limiting(torque_limiting), .coproc_present(coproc_present),
        .coproc_alive(coproc_alive), .ext_trip(ext_trip), .ext_trip_code(ext_trip_code),
        .parameter_conflict_fault(parameter_conflict_fault), .keypad_link_ok(keypad_link_ok),
        .self_diagnosis_fault(self_diagnosis_fault),
        .operation_blocked_fault(operation_blocked_fault), .fault_reset(fault_reset),
        .overload_state(overload_state), .powered_time_counter(powered_time_counter),
        .enabled_time_counter(enabled_time_counter), .speed_reference(speed_reference),
        .no_fault_relay(no_fault_relay), .with_error_relay(with_error_relay),
        .pwm_enable(pwm_enable), .motor_run_permit(motor_run_permit),
        .keypad_cmd_enable(keypad_cmd_enable), .display_code(display_code),
        .display_valid(display_valid), .error_lamp(error_lamp), .nv_write(nv_write),
        .nv_code(nv_code), .nv_overload(nv_overload), .nv_powered_time(nv_powered_time),
        .nv_enabled_time(nv_enabled_time), .nv_ref_valid(nv_ref_valid),
        .nv_speed_ref(nv_speed_ref), .hist_write(hist_write)
    );

    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end

    task automatic close_out;
        $display("errors %0d, comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard, well above the longest scenario
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (hist_write === 1'b1) hist_seen <= hist_seen + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // compares relays, pwm, permit, keypad enable and display against the bench model
    task automatic check_outs;
        logic stop, shown;
        logic [7:0] c;
        stop = m_trip | parameter_conflict_fault | self_diagnosis_fault | operation_blocked_fault;
        shown = m_trip | self_diagnosis_fault | parameter_conflict_fault | !keypad_link_ok;
        c = m_trip ? m_code : self_diagnosis_fault ? CODE_SELF_DIAG :
            parameter_conflict_fault ? CODE_CONFLICT : !keypad_link_ok ? CODE_KEYPAD : 8'h00;
        chk(no_fault_relay, !(m_trip | parameter_conflict_fault), "nofault");
        chk(with_error_relay, m_trip | parameter_conflict_fault, "witherr");
        chk(pwm_enable, !stop, "pwm");
        chk(motor_run_permit, !stop, "permit");
        chk(keypad_cmd_enable, keypad_link_ok, "keypad");
        chk(display_valid, shown, "dvalid");
        if (shown) chk(display_code, c, "dcode");
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && a == ADDR_CTRL) m_bk = d[CTRL_BACKUP];
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        {psel, penable, pwrite, torque_limiting, coproc_present, coproc_alive} <= '0;
        {ext_trip, fault_reset, parameter_conflict_fault} <= '0;
        {self_diagnosis_fault, operation_blocked_fault} <= '0;
        keypad_link_ok <= 1'b1;
        speed_actual <= 16'sh0000;
        speed_command <= 16'sh0000;
        m_trip = 0;
        m_bk = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
    endtask

    task automatic trip_ext(input logic [7:0] c);
        logic [15:0] ov, sr;
        logic [31:0] pt, et;
        @(posedge pclk);
        ov = $random(seed);
        sr = $random(seed);
        pt = $random(seed);
        et = $random(seed);
        overload_state <= ov;
        speed_reference <= sr;
        powered_time_counter <= pt;
        enabled_time_counter <= et;
        ext_trip <= 1'b1;
        ext_trip_code <= c;
        settle(1);
        chk(nv_write, 1'b1, "nvw");
        chk(hist_write, 1'b1, "histw");
        chk({nv_code, nv_overload}, {c, ov}, "nvdata");
        chk(nv_powered_time ^ nv_enabled_time, pt ^ et, "nvtime");
        chk(nv_ref_valid, m_bk, "refv");
        if (m_bk) chk(nv_speed_ref, sr, "ref");
        @(posedge pclk);
        ext_trip <= 1'b0;
        m_trip = 1;
        m_code = c;
        #1;
        chk(nv_write, 1'b0, "nvpulse");
        check_outs();
    endtask

    task automatic wait_code(input logic [7:0] c, input int lim);
        n = 0;
        while (display_code !== c && n < lim) begin
            settle(1);
            n = n + 1;
        end
        chk(display_code, c, "tripcode");
        m_trip = 1;
        m_code = c;
        settle(2);
        check_outs();
    endtask

    initial begin
        {psel, penable, pwrite} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        {torque_limiting, coproc_present, coproc_alive, ext_trip, fault_reset} = '0;
        ext_trip_code = 8'h00;
        {parameter_conflict_fault, self_diagnosis_fault, operation_blocked_fault} = '0;
        keypad_link_ok = 1'b1;
        speed_actual = 16'sh0000;
        speed_command = 16'sh0000;
        {overload_state, speed_reference} = '0;
        {powered_time_counter, enabled_time_counter} = '0;
        do_reset();
        check_outs();
        chk(error_lamp, 1'b0, "lamp idle");
        apb(1'b0, ADDR_SPD, 32'h0);
        chk(rd, {6'h00, SPD_TIME_RST, MAXERR_RST}, "spd rst");
        apb(1'b0, ADDR_TRQ, 32'h0);
        chk(rd, {22'h0, TRQ_TIME_RST}, "trq rst");
        apb(1'b0, 8'h1C, 32'h0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped");
        // timed faults with both times at their disabling values, vector mode
        apb(1'b1, ADDR_CTRL, {29'h0, MODE_VEC_SL});
        speed_actual <= 16'sh0400;
        torque_limiting <= 1'b1;
        settle(200);
        check_outs();
        // short times but scalar mode: must stay quiet
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_SPD, 32'h0001_000A);
        apb(1'b1, ADDR_TRQ, 32'h1);
        settle(120);
        check_outs();
        torque_limiting <= 1'b0;
        apb(1'b1, ADDR_CTRL, {29'h0, MODE_VEC_SL});
        wait_code(CODE_SPEED_LOSS, 100);
        // second trip while latched keeps the first code
        @(posedge pclk);
        speed_actual <= 16'sh0000;
        ext_trip <= 1'b1;
        ext_trip_code <= 8'h05;
        @(posedge pclk);
        ext_trip <= 1'b0;
        settle(3);
        check_outs();
        // clear and new event in one cycle: the new trip wins
        @(posedge pclk);
        fault_reset <= 1'b1;
        ext_trip <= 1'b1;
        @(posedge pclk);
        fault_reset <= 1'b0;
        ext_trip <= 1'b0;
        m_code = 8'h05;
        settle(3);
        check_outs();
        @(posedge pclk);
        fault_reset <= 1'b1;
        @(posedge pclk);
        fault_reset <= 1'b0;
        m_trip = 0;
        settle(3);
        check_outs();
        // torque timeout, encoder vector mode: 10 ticks per second
        apb(1'b1, ADDR_CTRL, {29'h0, MODE_VEC_ENC});
        torque_limiting <= 1'b1;
        settle(30);
        check_outs();
        wait_code(CODE_TRQ_TIMEOUT, 100);
        do_reset();
        coproc_present <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            settle(20);
            coproc_alive <= 1'b1;
            settle(1);
            coproc_alive <= 1'b0;
        end
        check_outs();
        wait_code(CODE_WDOG, 100);
        // external trip with backup set, lamp flash count, irq path
        do_reset();
        apb(1'b1, ADDR_CTRL, 32'h8);
        apb(1'b1, ADDR_IRQ_MASK, 32'hF);
        trip_ext(8'h03);
        prev = error_lamp;
        rises = 0;
        for (int i = 0; i < 84; i++) begin
            settle(1);
            if (error_lamp === 1'b1 && prev === 1'b0) rises = rises + 1;
            prev = error_lamp;
        end
        chk(rises, 3, "flashes");
        chk(irq, 1'b1, "irq");
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd[9:0], {2'b01, 8'h03}, "stat");
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        chk(rd[3:0], 4'h1, "irq st");
        apb(1'b1, ADDR_CMD, 32'h1);
        m_trip = 0;
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        settle(2);
        chk({irq, rd[3:0]}, 5'h00, "irq clr");
        check_outs();
        trip_ext(CODE_ZERO);
        settle(30);
        chk(error_lamp, 1'b1, "steady");
        // non-latched faults, one after another
        do_reset();
        parameter_conflict_fault <= 1'b1;
        settle(3);
        check_outs();
        parameter_conflict_fault <= 1'b0;
        settle(3);
        check_outs();
        hist_seen = 0;
        keypad_link_ok <= 1'b0;
        settle(30);
        check_outs();
        chk(hist_seen, 0, "hist");
        keypad_link_ok <= 1'b1;
        operation_blocked_fault <= 1'b1;
        settle(3);
        check_outs();
        operation_blocked_fault <= 1'b0;
        self_diagnosis_fault <= 1'b1;
        // first flash lasts at least five cycles, whatever the tick phase
        rises = 0;
        for (int i = 0; i < 8; i++) begin
            settle(1);
            if (error_lamp === 1'b1) rises = rises + 1;
        end
        check_outs();
        chk(rises >= 5, 1'b1, "diag lamp");
        close_out();
    end
endmodule
`default_nettype wire
